// *** core/wtr_pkg.sv ***
// Package of register offsets, field positions and constants for the time-code readout block.
package wtr_pkg;

    // ==========================================================
    // Register indices (printed offsets are not all multiples of four).
    localparam logic [7:0] IDX_CFG2       = 8'h28;
    localparam logic [7:0] IDX_STATUS     = 8'h29;
    localparam logic [7:0] IDX_FREQ_HIGH  = 8'h2A;
    localparam logic [7:0] IDX_FREQ_LOW   = 8'h2B;
    localparam logic [7:0] IDX_TC_UPPER   = 8'h2C;
    localparam logic [7:0] IDX_TC_LAST    = 8'h2D;
    localparam logic [7:0] IDX_PEAK       = 8'h2E;
    localparam logic [7:0] IDX_CRC_ERR    = 8'h38;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h41;

    // ==========================================================
    // Status register field positions.
    localparam int ST_READY      = 7;
    localparam int ST_BUSY       = 6;
    localparam int ST_CRC_GOOD   = 5;
    localparam int ST_INCOMPLETE = 4;
    localparam int ST_SYNC_ERR   = 1;
    localparam int ST_INTERP     = 0;

    // ==========================================================
    // Configuration 2 field positions.
    localparam int CFG_LP_LSB = 3;
    localparam int CFG_HP_LSB = 0;
    localparam int CODE_W     = 3;

    // ==========================================================
    // Interrupt event bits.
    localparam int IRQ_READY      = 0;
    localparam int IRQ_SYNC_ERR   = 1;
    localparam int IRQ_INTERP     = 2;
    localparam int IRQ_INCOMPLETE = 3;
    localparam int IRQ_CRC_FAIL   = 4;
    localparam int IRQ_W          = 5;

    // ==========================================================
    // Reset values and limits.
    localparam logic [7:0]  CFG2_RESET   = 8'h00;
    localparam logic [15:0] FREQ_RESET   = 16'h0000;
    localparam logic [7:0]  CRC_ERR_MAX  = 8'hFF;
    localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

    // Bandwidth selected by each code at the reference system clock, in Hz.
    localparam int unsigned REF_SYSCLK_HZ = 4260000;
    localparam int unsigned BW_HZ [8] = '{43000, 21500, 10700, 5400, 2700, 1350, 670, 350};

    // Byte position in the time-code read sequence.
    typedef enum logic [1:0] {WTR_SEQ_IDLE, WTR_SEQ_MID, WTR_SEQ_LAST} wtr_seq_t;

endpackage : wtr_pkg

// *** core/wtr_regs.sv ***
// Register bank of the wobble time-code readout, reached over APB.
`timescale 1ns/1ps

// Functional notes
// - Bandwidth codes 0..7 select 43 kHz halving down to 350 Hz.
// - Status bit 7 shows a time-code word is ready; interrupt source.
// - Status bit 6 is busy while a word read is in progress.
// - Status bit 5 shows CRC pass of current word; bit 4 flags an incomplete read; bits 3..2 reserved.
// - Status bit 1 flags sync out of phase; resync on next in-phase sync.
// - Status bit 0 flags a flywheel interpolated sync.
// - PLL frequency is read/write as high byte 2AH, low byte 2BH.
// - Consecutive data reads return bits 23..16 then bits 15..8.
// - Data-end register returns bits 7..0 of the word.
// - Read-only register holds the recovered bit signal peak value.
// - Unbuffered counter increments for every word failing CRC.
// - Error counter saturates at 255 and clears when read.
// - Config 2 holds low-pass code bits 5..3, high-pass bits 2..0.
module wtr_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // APB slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ADDR_W-1:0]              paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // Wobble processor side
    input  wire logic                           word_valid,
    input  wire logic [23:0]                    word_data,
    input  wire logic                           word_crc_good,
    input  wire logic                           sync_detected,
    input  wire logic                           sync_in_phase,
    input  wire logic                           sync_interp,
    input  wire logic                           freq_update,
    input  wire logic [15:0]                    freq_in,
    input  wire logic [7:0]                     peak_in,
    output logic      [wtr_pkg::CODE_W-1:0]     pll_lowpass_bw_code,
    output logic      [wtr_pkg::CODE_W-1:0]     pll_highpass_bw_code,
    output logic      [15:0]                    wobble_pll_frequency,
    output logic                                freq_load,
    output logic                                resync_req,
    // Interrupt
    output logic                                irq
);
    import wtr_pkg::*;

    // The map needs index bits 9..2 plus at least one upper bit checked for zero.
    if (ADDR_W < 11) begin : g_addr_w_check
        $error("ADDR_W too small for the register map");
    end

    // ==========================================================
    // State.
    typedef struct packed {
        logic [7:0]        cfg2;
        logic [15:0]       freq;
        logic              freq_load;
        logic [23:0]       word;
        logic              ready;
        logic              crc_good;
        logic              incomplete;
        logic              sync_err;
        logic              interp;
        logic              resync;
        wtr_seq_t          seq;
        logic [7:0]        peak;
        logic [7:0]        crc_err;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_mask;
        logic [31:0]       rdata;
        logic              ack;
    } wtr_state_t;

    wtr_state_t state_ff;
    wtr_state_t nxt_state;

    logic             access;
    logic             wr;
    logic             rd;
    logic [7:0]       idx;
    logic             word_aligned;
    logic             mapped;
    logic [7:0]       status_byte;
    logic [IRQ_W-1:0] events;

    assign access       = psel && penable;
    assign word_aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    assign idx          = paddr[9:2];
    // Reads act in the first access cycle so that prdata is a flop when pready rises.
    assign wr           = access && pwrite && word_aligned && state_ff.ack;
    assign rd           = access && !pwrite && word_aligned && !state_ff.ack;

    always_comb begin
        unique case (idx)
            IDX_CFG2, IDX_STATUS, IDX_FREQ_HIGH, IDX_FREQ_LOW, IDX_TC_UPPER,
            IDX_TC_LAST, IDX_PEAK, IDX_CRC_ERR, IDX_IRQ_STATUS, IDX_IRQ_MASK: begin
                mapped = word_aligned;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    always_comb begin
        status_byte                = 8'h00;
        status_byte[ST_READY]      = state_ff.ready;
        status_byte[ST_BUSY]       = (state_ff.seq != WTR_SEQ_IDLE);
        status_byte[ST_CRC_GOOD]   = state_ff.crc_good;
        status_byte[ST_INCOMPLETE] = state_ff.incomplete;
        status_byte[ST_SYNC_ERR]   = state_ff.sync_err;
        status_byte[ST_INTERP]     = state_ff.interp;
    end

    // ==========================================================
    // Next-state logic.
    always_comb begin
        nxt_state           = state_ff;
        nxt_state.freq_load = 1'b0;
        nxt_state.resync    = 1'b0;
        nxt_state.ack       = access && !state_ff.ack;
        events              = '0;
        nxt_state.peak      = peak_in;

        if (freq_update) begin
            nxt_state.freq = freq_in;
        end

        if (sync_interp) begin
            nxt_state.interp   = 1'b1;
            events[IRQ_INTERP] = 1'b1;
        end else if (sync_detected) begin
            nxt_state.interp = 1'b0;
        end

        if (sync_detected && !sync_in_phase) begin
            if (!state_ff.sync_err) begin
                events[IRQ_SYNC_ERR] = 1'b1;
            end
            nxt_state.sync_err = 1'b1;
        end else if (sync_detected && state_ff.sync_err) begin
            nxt_state.resync   = 1'b1;
            nxt_state.sync_err = 1'b0;
        end

        // Register reads and their side effects.
        if (rd) begin
            unique case (idx)
                IDX_CFG2: begin
                    nxt_state.rdata = {24'h0, state_ff.cfg2};
                end
                IDX_STATUS: begin
                    nxt_state.rdata = {24'h0, status_byte};
                end
                IDX_FREQ_HIGH: begin
                    nxt_state.rdata = {24'h0, state_ff.freq[15:8]};
                end
                IDX_FREQ_LOW: begin
                    nxt_state.rdata = {24'h0, state_ff.freq[7:0]};
                end
                IDX_TC_UPPER: begin
                    if (state_ff.seq == WTR_SEQ_IDLE) begin
                        nxt_state.rdata = {24'h0, state_ff.word[23:16]};
                        nxt_state.seq   = WTR_SEQ_MID;
                    end else begin
                        nxt_state.rdata = {24'h0, state_ff.word[15:8]};
                        nxt_state.seq   = WTR_SEQ_LAST;
                    end
                end
                IDX_TC_LAST: begin
                    nxt_state.rdata = {24'h0, state_ff.word[7:0]};
                    if (state_ff.seq != WTR_SEQ_LAST) begin
                        nxt_state.incomplete   = 1'b1;
                        events[IRQ_INCOMPLETE] = 1'b1;
                    end else begin
                        nxt_state.incomplete = 1'b0;
                    end
                    nxt_state.seq   = WTR_SEQ_IDLE;
                    nxt_state.ready = 1'b0;
                end
                IDX_PEAK: begin
                    nxt_state.rdata = {24'h0, state_ff.peak};
                end
                IDX_CRC_ERR: begin
                    nxt_state.rdata   = {24'h0, state_ff.crc_err};
                    nxt_state.crc_err = 8'h00;
                end
                IDX_IRQ_STATUS: begin
                    nxt_state.rdata = {{(32-IRQ_W){1'b0}}, state_ff.irq_status};
                end
                IDX_IRQ_MASK: begin
                    nxt_state.rdata = {{(32-IRQ_W){1'b0}}, state_ff.irq_mask};
                end
                default: begin
                    nxt_state.rdata = UNMAPPED_VAL;
                end
            endcase
        end else if (access && !state_ff.ack) begin
            nxt_state.rdata = UNMAPPED_VAL;
        end

        // Register writes, honoring byte lane 0 strobe.
        if (wr && pstrb[0]) begin
            unique case (idx)
                IDX_CFG2: begin
                    nxt_state.cfg2 = {2'b00, pwdata[5:0]};
                end
                IDX_FREQ_HIGH: begin
                    nxt_state.freq[15:8] = pwdata[7:0];
                    nxt_state.freq_load  = 1'b1;
                end
                IDX_FREQ_LOW: begin
                    nxt_state.freq[7:0] = pwdata[7:0];
                    nxt_state.freq_load = 1'b1;
                end
                IDX_IRQ_STATUS: begin
                    nxt_state.irq_status = state_ff.irq_status & ~pwdata[IRQ_W-1:0];
                end
                IDX_IRQ_MASK: begin
                    nxt_state.irq_mask = pwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // New word capture; wins over an end read in the same cycle.
        if (word_valid) begin
            nxt_state.word     = word_data;
            nxt_state.crc_good = word_crc_good;
            nxt_state.ready    = 1'b1;
            events[IRQ_READY]  = 1'b1;
            if (state_ff.seq != WTR_SEQ_IDLE) begin
                nxt_state.incomplete   = 1'b1;
                events[IRQ_INCOMPLETE] = 1'b1;
                nxt_state.seq          = WTR_SEQ_IDLE;
            end
            if (!word_crc_good) begin
                events[IRQ_CRC_FAIL] = 1'b1;
                if (state_ff.crc_err != CRC_ERR_MAX) begin
                    nxt_state.crc_err = (rd && idx == IDX_CRC_ERR) ? 8'h01
                                                                   : state_ff.crc_err + 8'h01;
                end else if (rd && idx == IDX_CRC_ERR) begin
                    nxt_state.crc_err = 8'h01;
                end
            end
        end

        // Sticky events; a set wins over a write-one clear.
        nxt_state.irq_status = nxt_state.irq_status | events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '{cfg2: CFG2_RESET, freq: FREQ_RESET, seq: WTR_SEQ_IDLE, default: '0};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // Outputs.
    assign prdata               = state_ff.rdata;
    assign pready               = state_ff.ack;
    assign pslverr              = access && !mapped;
    assign pll_lowpass_bw_code  = state_ff.cfg2[CFG_LP_LSB +: CODE_W];
    assign pll_highpass_bw_code = state_ff.cfg2[CFG_HP_LSB +: CODE_W];
    assign wobble_pll_frequency = state_ff.freq;
    assign freq_load            = state_ff.freq_load;
    assign resync_req           = state_ff.resync;
    assign irq                  = |(state_ff.irq_status & state_ff.irq_mask);

endmodule : wtr_regs

// *** tb/wtr_regs_assertions.sv ***
// Concurrent checks on the ports of the time-code readout register bank.
`timescale 1ns/1ps
module wtr_regs_chk #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // APB
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [ADDR_W-1:0]          paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    // Wobble side
    input wire logic                       sync_detected,
    input wire logic                       sync_in_phase,
    input wire logic                       freq_update,
    input wire logic [15:0]                freq_in,
    input wire logic [7:0]                 peak_in,
    input wire logic [wtr_pkg::CODE_W-1:0] pll_lowpass_bw_code,
    input wire logic [wtr_pkg::CODE_W-1:0] pll_highpass_bw_code,
    input wire logic [15:0]                wobble_pll_frequency,
    input wire logic                       freq_load,
    input wire logic                       resync_req
);
    import wtr_pkg::*;
    localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'({IDX_CFG2, 2'b00});
    localparam logic [ADDR_W-1:0] A_ST = ADDR_W'({IDX_STATUS, 2'b00});
    localparam logic [ADDR_W-1:0] A_FH = ADDR_W'({IDX_FREQ_HIGH, 2'b00});
    localparam logic [ADDR_W-1:0] A_FL = ADDR_W'({IDX_FREQ_LOW, 2'b00});
    localparam logic [ADDR_W-1:0] A_PK = ADDR_W'({IDX_PEAK, 2'b00});
    logic wr_acc;
    logic rd_acc;
    assign wr_acc = psel && penable && pready && pwrite && pstrb[0];
    assign rd_acc = psel && penable && pready && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Checks.
    bw_code_a: assert property (wr_acc && paddr == A_CFG |=>
        pll_lowpass_bw_code == $past(pwdata[5:3]) && pll_highpass_bw_code == $past(pwdata[2:0]))
        else $error("bandwidth codes differ from written value");
    freq_high_a: assert property (wr_acc && paddr == A_FH |=>
        wobble_pll_frequency[15:8] == $past(pwdata[7:0])) else $error("frequency high byte wrong");
    freq_low_a: assert property (wr_acc && paddr == A_FL |=>
        wobble_pll_frequency[7:0] == $past(pwdata[7:0])) else $error("frequency low byte wrong");
    freq_load_a: assert property (freq_load |->
        $past(wr_acc && (paddr == A_FH || paddr == A_FL))) else $error("stray frequency load");
    freq_track_a: assert property (freq_update && !(wr_acc && (paddr == A_FH || paddr == A_FL))
        |=> wobble_pll_frequency == $past(freq_in)) else $error("tracked frequency not loaded");
    peak_read_a: assert property (rd_acc && paddr == A_PK |->
        prdata == {24'h000000, $past(peak_in, 2)}) else $error("peak value read wrong");
    resync_a: assert property (resync_req |->
        $past(sync_detected && sync_in_phase)) else $error("resync without in-phase sync");
    status_rsvd_a: assert property (rd_acc && paddr == A_ST |->
        prdata[31:8] == 24'h000000 && prdata[3:2] == 2'h0) else $error("reserved status bits set");
endmodule : wtr_regs_chk

bind wtr_regs wtr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .sync_detected(sync_detected),
    .sync_in_phase(sync_in_phase), .freq_update(freq_update), .freq_in(freq_in),
    .peak_in(peak_in), .pll_lowpass_bw_code(pll_lowpass_bw_code),
    .pll_highpass_bw_code(pll_highpass_bw_code), .wobble_pll_frequency(wobble_pll_frequency),
    .freq_load(freq_load), .resync_req(resync_req));

// *** tb/wtr_apb_master.sv ***
// APB master model standing in for the on-chip processor.
`timescale 1ns/1ps
module wtr_apb_master (
    // Clock
    input wire logic         pclk,
    // APB
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'hF;
    end
    // ==========================================================
    // One transfer; data and error are taken in the cycle in which pready is high.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic read_word(output logic [23:0] w);
        logic e;
        xfer(1'b0, 8'h2C, 8'h00, w[23:16], e);
        xfer(1'b0, 8'h2C, 8'h00, w[15:8], e);
        xfer(1'b0, 8'h2D, 8'h00, w[7:0], e);
    endtask : read_word
endmodule : wtr_apb_master

// *** tb/tb_wobble_timecode_readout_regs.sv ***
// Self-checking testbench of the time-code readout register bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_wobble_timecode_readout_regs;
    import wtr_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic word_valid = 1'b0, word_crc_good = 1'b0, sync_detected = 1'b0;
    logic sync_in_phase = 1'b0, sync_interp = 1'b0, freq_update = 1'b0;
    logic freq_load, resync_req;
    logic [23:0] word_data = 24'h000000;
    logic [15:0] freq_in = 16'h0000, wobble_pll_frequency;
    logic [7:0] peak_in = 8'h00, d;
    logic [2:0] pll_lowpass_bw_code, pll_highpass_bw_code;
    logic e;
    int num_errors = 0, checks = 0;
    always #5 pclk = ~pclk;
    wtr_apb_master m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    wtr_regs #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .word_valid(word_valid),
        .word_data(word_data), .word_crc_good(word_crc_good), .sync_detected(sync_detected),
        .sync_in_phase(sync_in_phase), .sync_interp(sync_interp), .freq_update(freq_update),
        .freq_in(freq_in), .peak_in(peak_in), .pll_lowpass_bw_code(pll_lowpass_bw_code),
        .pll_highpass_bw_code(pll_highpass_bw_code), .wobble_pll_frequency(wobble_pll_frequency),
        .freq_load(freq_load), .resync_req(resync_req), .irq(irq));
    // ==========================================================
    // Helpers.
    task automatic rd(input logic [7:0] idx);
        m.xfer(1'b0, idx, 8'h00, d, e);
    endtask : rd
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        m.xfer(1'b1, idx, v, d, e);
    endtask : wr
    task automatic put_word(input logic [23:0] w, input logic good);
        word_data <= w;
        word_crc_good <= good;
        word_valid <= 1'b1;
        @(posedge pclk);
        word_valid <= 1'b0;
        @(posedge pclk);
    endtask : put_word
    task automatic sync_ev(input logic det, input logic ph, input logic ip);
        sync_detected <= det;
        sync_in_phase <= ph;
        sync_interp <= ip;
        @(posedge pclk);
        sync_detected <= 1'b0;
        sync_interp <= 1'b0;
        @(posedge pclk);
    endtask : sync_ev
    // ==========================================================
    // Scenarios.
    task automatic t_cfg();
        for (int c = 0; c < 8; c++) begin
            wr(IDX_CFG2, {2'h0, 3'(c), 3'(7 - c)});
            @(negedge pclk);
            `CHK(pll_lowpass_bw_code, 3'(c))
            `CHK(pll_highpass_bw_code, 3'(7 - c))
            @(posedge pclk);
        end
    endtask : t_cfg
    task automatic t_freq();
        rd(IDX_FREQ_HIGH);
        `CHK(d, 8'h00)
        wr(IDX_FREQ_HIGH, 8'hA5);
        wr(IDX_FREQ_LOW, 8'h3C);
        `CHK(wobble_pll_frequency, 16'hA53C)
        rd(IDX_FREQ_LOW);
        `CHK(d, 8'h3C)
        freq_in <= 16'h1234;
        freq_update <= 1'b1;
        @(posedge pclk);
        freq_update <= 1'b0;
        @(posedge pclk);
        rd(IDX_FREQ_HIGH);
        `CHK(d, 8'h12)
    endtask : t_freq
    task automatic t_word();
        put_word(24'hC35A96, 1'b1);
        rd(IDX_STATUS);
        `CHK(d, 8'hA0)
        rd(IDX_TC_UPPER);
        `CHK(d, 8'hC3)
        rd(IDX_STATUS);
        `CHK(d, 8'hE0)
        rd(IDX_TC_UPPER);
        `CHK(d, 8'h5A)
        rd(IDX_TC_LAST);
        `CHK(d, 8'h96)
        rd(IDX_STATUS);
        `CHK(d, 8'h20)
        put_word(24'h000000, 1'b1);
        rd(IDX_TC_LAST);
        rd(IDX_STATUS);
        `CHK(d[ST_INCOMPLETE], 1'b1)
    endtask : t_word
    task automatic t_crc();
        repeat (2) put_word(24'h111111, 1'b0);
        rd(IDX_STATUS);
        `CHK(d[ST_CRC_GOOD], 1'b0)
        rd(IDX_CRC_ERR);
        `CHK(d, 8'h02)
        rd(IDX_CRC_ERR);
        `CHK(d, 8'h00)
        repeat (260) put_word(24'h222222, 1'b0);
        rd(IDX_CRC_ERR);
        `CHK(d, CRC_ERR_MAX)
    endtask : t_crc
    task automatic t_sync();
        sync_ev(1'b1, 1'b0, 1'b0);
        rd(IDX_STATUS);
        `CHK(d[1:0], 2'h2)
        sync_ev(1'b0, 1'b1, 1'b1);
        rd(IDX_STATUS);
        `CHK(d[1:0], 2'h3)
        sync_ev(1'b1, 1'b1, 1'b0);
        rd(IDX_STATUS);
        `CHK(d[1:0], 2'h0)
    endtask : t_sync
    task automatic t_irq();
        logic [23:0] w;
        m.read_word(w);
        `CHK(w, 24'h222222)
        wr(IDX_IRQ_MASK, 8'h00);
        wr(IDX_IRQ_STATUS, 8'hFF);
        put_word(24'h0F0F0F, 1'b1);
        `CHK(irq, 1'b0)
        rd(IDX_IRQ_STATUS);
        `CHK(d[IRQ_READY], 1'b1)
        wr(IDX_IRQ_MASK, 8'h01);
        `CHK(irq, 1'b1)
        wr(IDX_IRQ_STATUS, 8'h01);
        `CHK(irq, 1'b0)
        peak_in <= 8'h7E;
        rd(IDX_PEAK);
        `CHK(d, 8'h7E)
        m.xfer(1'b0, 8'h30, 8'h00, d, e);
        `CHK({e, d}, 9'h100)
    endtask : t_irq
    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(IDX_CRC_ERR);
        `CHK(d, 8'h00)
        t_cfg();
        t_freq();
        t_word();
        t_crc();
        t_sync();
        t_irq();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        final_report();
    end
endmodule : tb_wobble_timecode_readout_regs
